// ### verilog/core_xfer_defs.svh
`ifndef CORE_XFER_DEFS_SVH
`define CORE_XFER_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define CMD_OFS 8'h00
`define ADDR_OFS 8'h04
`define FLAGS_OFS 8'h08
`define SP_OFS 8'h0c
`define RDATA_OFS 8'h10
`define RSEL_OFS 8'h14

// Bit positions inside the status flags byte; the busy bit sits at 8, just above it.
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define BUSY_BIT 8

// Reset values.
`define FLAGS_RST 8'h00
`define SP_RST 16'h01ff
`define CMD_RST 24'h000000

// First register pair of the pointers; X, Y and Z follow in order.
`define PAIR_X 4'hd

// Execute cycles per instruction class.
`define LEN_ONE 2'h1
`define LEN_MEM 2'h2
`define LEN_PGM 2'h3

`endif

// ### verilog/core_xfer_pkg.sv
package core_xfer_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ROTATE_LEFT_CARRY = 5'h01,
        OP_ROTATE_RIGHT_CARRY = 5'h02,
        OP_FLAG_SET = 5'h03,
        OP_FLAG_CLEAR = 5'h04,
        OP_REGISTER_BIT_TO_T_FLAG = 5'h05,
        OP_T_FLAG_TO_REGISTER_BIT = 5'h06,
        OP_READ_INDIRECT = 5'h07,
        OP_READ_WITH_OFFSET = 5'h08,
        OP_READ_DIRECT = 5'h09,
        OP_MEM_WRITE_INDIRECT = 5'h0a,
        OP_WRITE_WITH_OFFSET = 5'h0b,
        OP_WRITE_DIRECT = 5'h0c,
        OP_PROGRAM_MEMORY_READ = 5'h0d,
        OP_PUSH = 5'h0e,
        OP_POP = 5'h0f,
        OP_SLEEP = 5'h10,
        OP_WATCHDOG_RESTART = 5'h11
    } op_t;

    typedef enum logic [1:0] {
        AM_PLAIN = 2'b00,
        AM_POST_INC = 2'b01,
        AM_PRE_DEC = 2'b10
    } amode_t;

    typedef enum logic [1:0] {
        WAIT_CMD = 2'b00,
        FETCH_OPS = 2'b01,
        EXECUTE = 2'b10
    } state_t;

    typedef struct packed {
        logic r0_dest;
        logic [5:0] disp;
        logic [2:0] bidx;
        amode_t amode;
        logic [1:0] ptr;
        logic [4:0] reg_no;
        op_t op;
    } cmd_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dmem_req_t;

endpackage

// ### verilog/work_regs.sv
`timescale 1ns/1ns
// Working registers held as pairs so pointer updates carry across bytes.
module work_regs
    import core_xfer_pkg::*;
#(
    parameter int PAIRS = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Byte and pair read ports
    input wire logic [4:0] i_ra,
    output logic [7:0] o_ra_data,
    input wire logic [3:0] i_rp,
    output logic [15:0] o_rp_data,
    // Pair write port with byte enables
    input wire logic [3:0] i_wp,
    input wire logic i_we_lo,
    input wire logic i_we_hi,
    input wire logic [15:0] i_wd
);
    logic [15:0] pair_q [PAIRS];

    for (genvar g = 0; g < PAIRS; g++) begin : g_pair
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                pair_q[g] <= 16'h0000;
            end else if (i_wp == 4'(g)) begin
                if (i_we_lo) pair_q[g][7:0] <= i_wd[7:0];
                if (i_we_hi) pair_q[g][15:8] <= i_wd[15:8];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_ra_data <= 8'h00;
            o_rp_data <= 16'h0000;
        end else begin
            o_ra_data <= i_ra[0] ? pair_q[i_ra[4:1]][15:8]
                                 : pair_q[i_ra[4:1]][7:0];
            o_rp_data <= pair_q[i_rp];
        end
    end
endmodule

// ### verilog/bit_unit.sv
`timescale 1ns/1ns
`include "core_xfer_defs.svh"
module bit_unit
    import core_xfer_pkg::*;
(
    // Operation and operands
    input wire op_t i_op,
    input wire logic [7:0] i_val,
    input wire logic [7:0] i_flags,
    input wire logic [2:0] i_bidx,
    // Results
    output logic [7:0] o_res,
    output logic [7:0] o_flags
);
    always_comb begin
        o_res = i_val;
        o_flags = i_flags;
        case (i_op)
            OP_ROTATE_LEFT_CARRY: begin
                o_res = {i_val[6:0], i_flags[`FLAG_C]};
                o_flags[`FLAG_C] = i_val[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                o_res = {i_flags[`FLAG_C], i_val[7:1]};
                o_flags[`FLAG_C] = i_val[0];
            end
            OP_FLAG_SET: o_flags[i_bidx] = 1'b1;
            OP_FLAG_CLEAR: o_flags[i_bidx] = 1'b0;
            OP_REGISTER_BIT_TO_T_FLAG: o_flags[`FLAG_T] = i_val[i_bidx];
            OP_T_FLAG_TO_REGISTER_BIT: o_res[i_bidx] = i_flags[`FLAG_T];
            default: o_res = i_val;
        endcase
        if (i_op == OP_ROTATE_LEFT_CARRY || i_op == OP_ROTATE_RIGHT_CARRY)
        begin
            o_flags[`FLAG_N] = o_res[7];
            o_flags[`FLAG_Z] = (o_res == 8'h00);
            o_flags[`FLAG_V] = o_res[7] ^ o_flags[`FLAG_C];
        end
    end
endmodule

// ### verilog/core_xfer.sv
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`include "core_xfer_defs.svh"
// Function
// (RULE1) Rotate left through carry; update Z, C, N, V in one cycle.
// (RULE2) Rotate right through carry; update Z, C, N, V in one cycle.
// (RULE3) One-cycle set of any single status flag; others unchanged.
// (RULE4) One-cycle clear of any single status flag; others unchanged.
// (RULE5) Copy selected register bit into T in one cycle.
// (RULE6) Write T into selected register bit; flags unchanged.
// (RULE7) Indirect read via X, Y, Z in two cycles, optional post-increment.
// (RULE8) Pre-decrement pointer, then read at the new address, two cycles.
// (RULE9) Read at Y or Z plus offset, pointer kept, two cycles.
// (RULE10) Read at immediate address in two cycles, flags untouched.
// (RULE11) Indirect write via X, Y, Z: plain, post-increment, pre-decrement.
// (RULE12) Write at Y or Z plus offset, pointer kept, two cycles.
// (RULE13) Write at immediate address in two cycles, flags untouched.
// (RULE14) Program memory byte at Z in three cycles, into R0 or named.
// (RULE15) Push register onto stack in two cycles, flags unchanged.
// (RULE16) Pop stack top into register in two cycles, flags unchanged.
// (RULE17) Sleep request issued in one cycle, flags unchanged.
// (RULE18) Watchdog restart pulse in one cycle, flags unchanged.
// (RULE19) X, Y, Z are 16-bit pairs of the top six registers.
module core_xfer
    import core_xfer_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Avalon-MM slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Data memory and stack
    output dmem_req_t o_dmem,
    input wire logic [7:0] i_dmem_rdata,
    // Program memory
    output logic o_pmem_rd,
    output logic [14:0] o_pmem_addr,
    input wire logic [15:0] i_pmem_rdata,
    // Power and watchdog control
    output logic o_sleep_req,
    output logic o_watchdog_restart
);
    state_t state_q;
    logic [1:0] step_q;
    cmd_t cmd_q;
    logic [15:0] addr_q;
    logic [15:0] sp_q;
    logic [7:0] flags_q;
    logic [4:0] sel_q;
    logic rdpend_q;
    logic byte_sel_q;
    logic [7:0] rd_val;
    logic [15:0] ptr_val;
    logic [7:0] bit_res;
    logic [7:0] bit_flags;
    logic req;
    logic is_rdata;
    logic stall;
    logic release_req;
    logic acc_wr;
    logic [4:0] dst;
    logic [4:0] rf_ra;
    logic [3:0] rf_rp;
    logic [3:0] rf_wp;
    logic rf_we_lo;
    logic rf_we_hi;
    logic [7:0] wbyte;
    logic [15:0] rf_wd;
    logic [1:0] len;
    logic exec1;
    logic last;
    logic is_load;
    logic is_store;
    logic [15:0] eff_addr;
    logic [15:0] ptr_next;
    logic ptr_upd;

    // Bus handshake. Writes and the register window stall while busy.
    assign req = i_avs_read | i_avs_write;
    assign is_rdata = (i_avs_address == `RDATA_OFS);
    assign stall = (state_q != WAIT_CMD) && (i_avs_write || is_rdata);
    // The register window needs one extra cycle for the registered read.
    assign release_req = req && o_avs_waitrequest && !stall &&
                         (!(i_avs_read && is_rdata) || rdpend_q);
    assign acc_wr = i_avs_write && !o_avs_waitrequest;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !release_req;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdpend_q <= 1'b0;
        end else if (req && !o_avs_waitrequest) begin
            rdpend_q <= 1'b0;
        end else if (i_avs_read && is_rdata && !stall) begin
            rdpend_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h00000000;
        end else if (release_req) begin
            if (i_avs_address == `CMD_OFS) begin
                o_avs_readdata <= {8'h00, cmd_q};
            end else if (i_avs_address == `ADDR_OFS) begin
                o_avs_readdata <= {16'h0000, addr_q};
            end else if (i_avs_address == `FLAGS_OFS) begin
                o_avs_readdata <= {23'h000000, state_q != WAIT_CMD, flags_q};
            end else if (i_avs_address == `SP_OFS) begin
                o_avs_readdata <= {16'h0000, sp_q};
            end else if (is_rdata) begin
                o_avs_readdata <= {24'h000000, rd_val};
            end else if (i_avs_address == `RSEL_OFS) begin
                o_avs_readdata <= {27'h0000000, sel_q};
            end else begin
                o_avs_readdata <= 32'h00000000;
            end
        end
    end

    // Software-written registers.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmd_q <= `CMD_RST;
            addr_q <= 16'h0000;
            sel_q <= 5'h00;
        end else if (acc_wr) begin
            if (i_avs_address == `CMD_OFS) begin
                cmd_q <= i_avs_writedata[23:0];
            end else if (i_avs_address == `ADDR_OFS) begin
                addr_q <= i_avs_writedata[15:0];
            end else if (i_avs_address == `RSEL_OFS) begin
                sel_q <= i_avs_writedata[4:0];
            end
        end
    end

    // Instruction sequencing.
    always_comb begin
        case (cmd_q.op)
            OP_READ_INDIRECT, OP_READ_WITH_OFFSET, OP_READ_DIRECT,
            OP_MEM_WRITE_INDIRECT, OP_WRITE_WITH_OFFSET, OP_WRITE_DIRECT,
            OP_PUSH, OP_POP: len = `LEN_MEM; // RULE7 RULE11 RULE15 RULE16
            OP_PROGRAM_MEMORY_READ: len = `LEN_PGM; // RULE14
            default: len = `LEN_ONE; // RULE3 RULE17 RULE18
        endcase
    end

    assign exec1 = (state_q == EXECUTE) && (step_q == 2'h1);
    assign last = (state_q == EXECUTE) && (step_q == len);
    assign is_load = (cmd_q.op == OP_READ_INDIRECT) ||
                     (cmd_q.op == OP_READ_WITH_OFFSET) ||
                     (cmd_q.op == OP_READ_DIRECT) || (cmd_q.op == OP_POP);
    assign is_store = (cmd_q.op == OP_MEM_WRITE_INDIRECT) ||
                      (cmd_q.op == OP_WRITE_WITH_OFFSET) ||
                      (cmd_q.op == OP_WRITE_DIRECT) || (cmd_q.op == OP_PUSH);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= WAIT_CMD;
            step_q <= 2'h0;
        end else begin
            case (state_q)
                WAIT_CMD: begin
                    if (acc_wr && i_avs_address == `CMD_OFS) begin
                        state_q <= FETCH_OPS;
                    end
                end
                FETCH_OPS: begin
                    state_q <= EXECUTE;
                    step_q <= 2'h1;
                end
                EXECUTE: begin
                    if (step_q == len) begin
                        state_q <= WAIT_CMD;
                        step_q <= 2'h0;
                    end else begin
                        step_q <= step_q + 2'h1;
                    end
                end
                default: begin
                    state_q <= WAIT_CMD;
                    step_q <= 2'h0;
                end
            endcase
        end
    end

    // Operand access and addressing.
    assign dst = (cmd_q.op == OP_PROGRAM_MEMORY_READ && cmd_q.r0_dest)
                 ? 5'h00 : cmd_q.reg_no; // RULE14
    assign rf_ra = (state_q == WAIT_CMD) ? sel_q : dst;
    assign rf_rp = `PAIR_X + {2'b00, cmd_q.ptr}; // RULE19

    always_comb begin
        ptr_next = ptr_val;
        ptr_upd = 1'b0;
        eff_addr = ptr_val;
        if (cmd_q.amode == AM_POST_INC) begin
            ptr_next = ptr_val + 16'h0001; // RULE19
        end else if (cmd_q.amode == AM_PRE_DEC) begin
            ptr_next = ptr_val - 16'h0001;
        end
        case (cmd_q.op)
            OP_READ_INDIRECT, OP_MEM_WRITE_INDIRECT: begin
                ptr_upd = (cmd_q.amode == AM_POST_INC) ||
                          (cmd_q.amode == AM_PRE_DEC); // RULE7 RULE11
                if (cmd_q.amode == AM_PRE_DEC) begin
                    eff_addr = ptr_next; // RULE8 RULE11
                end
            end
            OP_READ_WITH_OFFSET, OP_WRITE_WITH_OFFSET:
                eff_addr = ptr_val + {10'h000, cmd_q.disp}; // RULE9 RULE12
            OP_READ_DIRECT, OP_WRITE_DIRECT:
                eff_addr = addr_q; // RULE10 RULE13
            OP_PROGRAM_MEMORY_READ:
                ptr_upd = (cmd_q.amode == AM_POST_INC); // RULE14
            OP_PUSH: eff_addr = sp_q;
            OP_POP: eff_addr = sp_q + 16'h0001;
            default: eff_addr = ptr_val;
        endcase
    end

    // One write port: bus window, byte results, pointer pairs, load data.
    always_comb begin
        rf_wp = dst[4:1];
        rf_we_lo = 1'b0;
        rf_we_hi = 1'b0;
        wbyte = bit_res;
        rf_wd = {wbyte, wbyte};
        if (acc_wr && is_rdata) begin
            rf_wp = sel_q[4:1];
            wbyte = i_avs_writedata[7:0];
            rf_wd = {wbyte, wbyte};
            rf_we_lo = !sel_q[0];
            rf_we_hi = sel_q[0];
        end else if (exec1 && (cmd_q.op == OP_ROTATE_LEFT_CARRY ||
                 cmd_q.op == OP_ROTATE_RIGHT_CARRY ||
                 cmd_q.op == OP_T_FLAG_TO_REGISTER_BIT)) begin
            rf_we_lo = !dst[0]; // RULE1 RULE2 RULE6
            rf_we_hi = dst[0];
        end else if (exec1 && ptr_upd) begin
            rf_wp = rf_rp;
            rf_wd = ptr_next; // RULE19
            rf_we_lo = 1'b1;
            rf_we_hi = 1'b1;
        end else if (last && is_load) begin
            wbyte = i_dmem_rdata; // RULE7 RULE16
            rf_wd = {wbyte, wbyte};
            rf_we_lo = !dst[0];
            rf_we_hi = dst[0];
        end else if (last && cmd_q.op == OP_PROGRAM_MEMORY_READ) begin
            wbyte = byte_sel_q ? i_pmem_rdata[15:8] : i_pmem_rdata[7:0];
            rf_wd = {wbyte, wbyte}; // RULE14
            rf_we_lo = !dst[0];
            rf_we_hi = dst[0];
        end
    end

    work_regs u_regs (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ra(rf_ra),
        .o_ra_data(rd_val),
        .i_rp(rf_rp),
        .o_rp_data(ptr_val),
        .i_wp(rf_wp),
        .i_we_lo(rf_we_lo),
        .i_we_hi(rf_we_hi),
        .i_wd(rf_wd)
    );

    bit_unit u_bits (
        .i_op(cmd_q.op),
        .i_val(rd_val),
        .i_flags(flags_q),
        .i_bidx(cmd_q.bidx),
        .o_res(bit_res),
        .o_flags(bit_flags)
    );

    // Status flags. Only the bit unit changes them during execution.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flags_q <= `FLAGS_RST;
        end else if (acc_wr && i_avs_address == `FLAGS_OFS) begin
            flags_q <= i_avs_writedata[7:0];
        end else if (exec1) begin
            flags_q <= bit_flags; // RULE1 RULE2 RULE3 RULE4 RULE5
        end
    end

    // Stack pointer: push stores then decrements, pop increments first.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sp_q <= `SP_RST;
        end else if (acc_wr && i_avs_address == `SP_OFS) begin
            sp_q <= i_avs_writedata[15:0];
        end else if (exec1 && cmd_q.op == OP_PUSH) begin
            sp_q <= sp_q - 16'h0001; // RULE15
        end else if (exec1 && cmd_q.op == OP_POP) begin
            sp_q <= sp_q + 16'h0001; // RULE16
        end
    end

    // Memory strobes stand for the second execute cycle only.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_dmem <= '0;
        end else begin
            o_dmem.rd <= exec1 && is_load; // RULE7 RULE9 RULE10 RULE16
            o_dmem.wr <= exec1 && is_store; // RULE11 RULE12 RULE13 RULE15
            if (exec1) begin
                o_dmem.addr <= eff_addr;
                o_dmem.wdata <= rd_val;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pmem_rd <= 1'b0;
            o_pmem_addr <= 15'h0000;
            byte_sel_q <= 1'b0;
        end else begin
            o_pmem_rd <= exec1 && cmd_q.op == OP_PROGRAM_MEMORY_READ;
            if (exec1) begin
                o_pmem_addr <= eff_addr[15:1]; // RULE14
                byte_sel_q <= eff_addr[0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sleep_req <= 1'b0;
            o_watchdog_restart <= 1'b0;
        end else begin
            o_sleep_req <= exec1 && cmd_q.op == OP_SLEEP; // RULE17
            o_watchdog_restart <= exec1 &&
                cmd_q.op == OP_WATCHDOG_RESTART; // RULE18
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    chk_rotl_flags: assert property ( // RULE1
        exec1 && cmd_q.op == OP_ROTATE_LEFT_CARRY |=>
        flags_q[`FLAG_C] == $past(rd_val[7]) &&
        flags_q[`FLAG_N] == $past(rd_val[6]) &&
        flags_q[`FLAG_V] == (flags_q[`FLAG_N] ^ flags_q[`FLAG_C]))
        else $error("rotate left flags wrong");
    chk_rotr_flags: assert property ( // RULE2
        exec1 && cmd_q.op == OP_ROTATE_RIGHT_CARRY |=>
        flags_q[`FLAG_C] == $past(rd_val[0]) &&
        flags_q[`FLAG_N] == $past(flags_q[`FLAG_C]))
        else $error("rotate right flags wrong");
    chk_flag_set: assert property ( // RULE3
        exec1 && cmd_q.op == OP_FLAG_SET |=>
        flags_q == ($past(flags_q) | (8'h01 << $past(cmd_q.bidx))))
        else $error("flag set touched other flags");
    chk_flag_clear: assert property ( // RULE4
        exec1 && cmd_q.op == OP_FLAG_CLEAR |=>
        flags_q == ($past(flags_q) & ~(8'h01 << $past(cmd_q.bidx))))
        else $error("flag clear touched other flags");
    chk_bit_to_t: assert property ( // RULE5
        exec1 && cmd_q.op == OP_REGISTER_BIT_TO_T_FLAG |=>
        flags_q[`FLAG_T] == $past(rd_val[cmd_q.bidx]))
        else $error("T flag not loaded from register bit");
    chk_t_to_bit: assert property ( // RULE6
        exec1 && cmd_q.op == OP_T_FLAG_TO_REGISTER_BIT |=>
        $stable(flags_q) && state_q == WAIT_CMD)
        else $error("bit load changed flags or overran");

    sequence load_steps;
        exec1 && !o_dmem.rd ##1 o_dmem.rd && last ##1 state_q == WAIT_CMD;
    endsequence
    chk_load_time: assert property ( // RULE7
        state_q == FETCH_OPS && is_load |=> load_steps)
        else $error("load did not finish in two cycles");
    chk_predec_addr: assert property ( // RULE8
        exec1 && cmd_q.op == OP_READ_INDIRECT &&
        cmd_q.amode == AM_PRE_DEC |=>
        o_dmem.addr == $past(ptr_val) - 16'h0001)
        else $error("pre-decrement address wrong");
    chk_offset_addr: assert property ( // RULE9
        exec1 && (cmd_q.op == OP_READ_WITH_OFFSET ||
        cmd_q.op == OP_WRITE_WITH_OFFSET) |=>
        o_dmem.addr == $past(ptr_val) + {10'h000, $past(cmd_q.disp)})
        else $error("offset address wrong");
    chk_direct_addr: assert property ( // RULE10
        exec1 && (cmd_q.op == OP_READ_DIRECT ||
        cmd_q.op == OP_WRITE_DIRECT) |=>
        o_dmem.addr == $past(addr_q) && $stable(flags_q))
        else $error("direct address wrong or flags moved");
    chk_store_strobe: assert property ( // RULE11
        exec1 && is_store |=>
        o_dmem.wr && o_dmem.wdata == $past(rd_val) ##1 !o_dmem.wr)
        else $error("store strobe or data wrong");

    sequence pgm_steps;
        exec1 ##1 o_pmem_rd ##1 last && !o_pmem_rd ##1 state_q == WAIT_CMD;
    endsequence
    chk_pgm_time: assert property ( // RULE14
        state_q == FETCH_OPS && cmd_q.op == OP_PROGRAM_MEMORY_READ |=>
        pgm_steps)
        else $error("program memory read not three cycles");
    chk_push_stack: assert property ( // RULE15
        exec1 && cmd_q.op == OP_PUSH |=>
        o_dmem.wr && o_dmem.addr == $past(sp_q) &&
        sp_q == $past(sp_q) - 16'h0001 && $stable(flags_q))
        else $error("push stack access wrong");
    chk_pop_stack: assert property ( // RULE16
        exec1 && cmd_q.op == OP_POP |=>
        o_dmem.rd && o_dmem.addr == $past(sp_q) + 16'h0001 &&
        o_dmem.addr == sp_q)
        else $error("pop stack access wrong");
    chk_sleep_pulse: assert property ( // RULE17
        exec1 && cmd_q.op == OP_SLEEP |=>
        o_sleep_req && $stable(flags_q) ##1 !o_sleep_req)
        else $error("sleep request not a single pulse");
    chk_wdog_pulse: assert property ( // RULE18
        exec1 && cmd_q.op == OP_WATCHDOG_RESTART |=>
        o_watchdog_restart ##1 !o_watchdog_restart)
        else $error("watchdog restart not a single pulse");
endmodule

// ### bench/mem_model.sv
`timescale 1ns/1ns
// Data SRAM with combinational read, program memory with one-cycle read.
module mem_model
    import core_xfer_pkg::*;
(
    // Core side
    input wire logic i_clk,
    input wire dmem_req_t i_dmem,
    input wire logic i_prd,
    input wire logic [14:0] i_paddr,
    // Answers
    output logic [7:0] o_drd,
    output logic [15:0] o_pword
);
    logic [7:0] ram [0:511];
    logic [7:0] last = 8'h00;
    initial o_pword = 16'h0000;
    initial for (int i = 0; i < 512; i++) ram[i] = i[7:0] ^ 8'ha5;
    // Idle outputs toggle so a stale byte is never mistaken for data.
    assign o_drd = i_dmem.rd ? ram[i_dmem.addr[8:0]] : ~last;
    always @(posedge i_clk) begin
        if (i_dmem.wr) ram[i_dmem.addr[8:0]] <= i_dmem.wdata;
        last <= o_drd;
        o_pword <= i_prd ? {~i_paddr[7:0], i_paddr[7:0]} : ~o_pword;
    end
endmodule

// ### bench/core_xfer_tb.sv
`timescale 1ns/1ns
`include "core_xfer_defs.svh"
module core_xfer_tb
    import core_xfer_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, q;
    logic waitr, prd, slp, wdg;
    dmem_req_t dm;
    logic [7:0] drd;
    logic [14:0] pa;
    logic [15:0] pw;
    int n_errors = 0;
    int checked = 0;
    int ticks = 0;
    int n_slp = 0;
    int n_wdg = 0;
    core_xfer i_core_xfer (.i_clk, .i_reset, .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(waitr), .o_dmem(dm),
        .i_dmem_rdata(drd), .o_pmem_rd(prd), .o_pmem_addr(pa),
        .i_pmem_rdata(pw), .o_sleep_req(slp), .o_watchdog_restart(wdg));
    mem_model i_mem_model (.i_clk, .i_dmem(dm), .i_prd(prd),
        .i_paddr(pa), .o_drd(drd), .o_pword(pw));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ticks <= ticks + 1;
        n_slp <= n_slp + int'(slp);
        n_wdg <= n_wdg + int'(wdg);
        if (ticks == 4000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge i_clk);
        wr <= w;
        rd <= ~w;
        adr <= a;
        wd <= d;
        do @(posedge i_clk); while (waitr !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic setr(logic [4:0] n, logic [7:0] v);
        bus(1, `RSEL_OFS, {27'h0, n});
        bus(1, `RDATA_OFS, {24'h0, v});
    endtask
    task automatic ckr(logic [4:0] n, logic [7:0] v);
        bus(1, `RSEL_OFS, {27'h0, n});
        bus(0, `RDATA_OFS, 32'h0);
        chk(q, {24'h0, v});
    endtask
    task automatic ckf(logic [7:0] m, logic [7:0] v);
        bus(0, `FLAGS_OFS, 32'h0);
        chk(q & {24'h0, m}, {24'h0, v});
    endtask
    // Unmapped write stalls while busy, so it marks the end of the op.
    task automatic run(op_t o, logic [4:0] r = 5'h0, logic [1:0] p = 2'h0,
        amode_t m = AM_PLAIN, logic [2:0] b = 3'h0, logic [5:0] ds = 6'h0,
        logic z = 1'b0);
        bus(1, `CMD_OFS, {8'h0, z, ds, b, m, p, r, o});
        bus(1, 8'h18, 32'hff);
    endtask
    task automatic rdd(logic [15:0] a, logic [7:0] v);
        bus(1, `ADDR_OFS, {16'h0, a});
        run(OP_READ_DIRECT, 5'h09);
        ckr(5'h09, v);
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        bus(0, `SP_OFS, 32'h0);
        chk(q, 32'h1ff);
        bus(1, `FLAGS_OFS, 32'h31);
        setr(5'h10, 8'h80);
        run(OP_ROTATE_LEFT_CARRY, 5'h10);
        ckr(5'h10, 8'h01);
        ckf(8'hf7, 8'h31);
        bus(1, `FLAGS_OFS, 32'h0);
        run(OP_ROTATE_RIGHT_CARRY, 5'h10);
        ckr(5'h10, 8'h00);
        ckf(8'hf7, 8'h03);
        for (int i = 0; i < 8; i++) begin
            bus(1, `FLAGS_OFS, 32'h0);
            run(OP_FLAG_SET, 5'h0, 2'h0, AM_PLAIN, i[2:0]);
            ckf(8'hff, 8'h1 << i);
            bus(1, `FLAGS_OFS, 32'hff);
            run(OP_FLAG_CLEAR, 5'h0, 2'h0, AM_PLAIN, i[2:0]);
            ckf(8'hff, ~(8'h1 << i));
        end
        bus(1, `FLAGS_OFS, 32'h0);
        setr(5'h05, 8'h20);
        run(OP_REGISTER_BIT_TO_T_FLAG, 5'h05, 2'h0, AM_PLAIN, 3'h5);
        ckf(8'hff, 8'h40);
        setr(5'h06, 8'hf0);
        run(OP_T_FLAG_TO_REGISTER_BIT, 5'h06, 2'h0, AM_PLAIN, 3'h3);
        ckr(5'h06, 8'hf8);
        setr(5'h1e, 8'hff);
        run(OP_READ_INDIRECT, 5'h01, 2'h2, AM_POST_INC);
        ckr(5'h01, 8'hff ^ 8'ha5);
        ckr(5'h1f, 8'h01);
        setr(5'h1a, 8'h10);
        run(OP_READ_INDIRECT, 5'h02, 2'h0, AM_PRE_DEC);
        ckr(5'h02, 8'h0f ^ 8'ha5);
        setr(5'h1c, 8'h20);
        run(OP_READ_WITH_OFFSET, 5'h03, 2'h1, AM_PLAIN, 3'h0, 6'h05);
        ckr(5'h03, 8'h25 ^ 8'ha5);
        ckr(5'h1c, 8'h20);
        rdd(16'h0040, 8'h40 ^ 8'ha5);
        setr(5'h07, 8'h3c);
        run(OP_WRITE_WITH_OFFSET, 5'h07, 2'h1, AM_PLAIN, 3'h0, 6'h3f);
        rdd(16'h005f, 8'h3c);
        run(OP_MEM_WRITE_INDIRECT, 5'h07, 2'h0, AM_POST_INC);
        rdd(16'h000f, 8'h3c);
        ckr(5'h1a, 8'h10);
        bus(1, `ADDR_OFS, 32'h0123);
        run(OP_WRITE_DIRECT, 5'h07);
        rdd(16'h0123, 8'h3c);
        run(OP_MEM_WRITE_INDIRECT, 5'h07, 2'h1, AM_PRE_DEC);
        rdd(16'h001f, 8'h3c);
        ckr(5'h1c, 8'h1f);
        setr(5'h1e, 8'h05);
        run(OP_PROGRAM_MEMORY_READ, 5'h0b, 2'h2, AM_POST_INC, 3'h0, 6'h0, 1);
        ckr(5'h00, 8'h7d);
        run(OP_PROGRAM_MEMORY_READ, 5'h0b, 2'h2);
        ckr(5'h0b, 8'h83);
        run(OP_PUSH, 5'h07);
        bus(0, `SP_OFS, 32'h0);
        chk(q, 32'h1fe);
        rdd(16'h01ff, 8'h3c);
        run(OP_POP, 5'h0c);
        ckr(5'h0c, 8'h3c);
        ckf(8'hff, 8'h40);
        run(OP_SLEEP);
        chk(n_slp, 1);
        run(OP_WATCHDOG_RESTART);
        chk(n_wdg, 1);
        ckf(8'hff, 8'h40);
        bus(0, 8'h18, 32'h0);
        chk(q, 32'h0);
        report_and_stop();
    end
endmodule
